// file: hw/dp_pkg.sv
// Constants for the microcoded datapath: microword fields, codes and reset values.
package dp_pkg;
  localparam int UI_W = 96;
  localparam int WORD_W = 24;
  localparam int BUS_W = 16;
  // Microword field positions (low bit of each field).
  localparam int F_AA = 0;
  localparam int F_AB = 4;
  localparam int F_FN = 8;
  localparam int F_SRC = 11;
  localparam int F_DST = 13;
  localparam int F_SH = 15;
  localparam int F_ZS = 18;
  localparam int F_ROT = 19;
  localparam int F_LN = 22;
  localparam int F_DS = 28;
  localparam int F_LIT = 30;
  localparam int F_SA = 54;
  localparam int F_SW = 56;
  localparam int F_AS = 57;
  localparam int F_AL = 59;
  localparam int F_HL = 62;
  localparam int F_OL = 63;
  localparam int F_BO = 64;
  localparam int F_PT = 66;
  localparam int F_FO = 67;
  localparam int F_FI = 69;
  // Arithmetic function codes.
  localparam logic [2:0] FN_ADD = 3'h0;
  localparam logic [2:0] FN_SUB = 3'h1;
  localparam logic [2:0] FN_AND = 3'h2;
  localparam logic [2:0] FN_OR = 3'h3;
  localparam logic [2:0] FN_XOR = 3'h4;
  localparam logic [2:0] FN_PR = 3'h5;
  localparam logic [2:0] FN_PS = 3'h6;
  // Shift codes.
  localparam logic [2:0] SH_L24 = 3'h1;
  localparam logic [2:0] SH_R24 = 3'h2;
  localparam logic [2:0] SH_L48 = 3'h3;
  localparam logic [2:0] SH_R48 = 3'h4;
  // Operand bus lane codes.
  localparam logic [1:0] LN_LIT = 2'h0;
  localparam logic [1:0] LN_HOLD = 2'h1;
  localparam logic [1:0] LN_ROT = 2'h2;
  // Backplane operation and flag operation codes.
  localparam logic [1:0] BO_WRITE = 2'h1;
  localparam logic [1:0] BO_READ = 2'h2;
  localparam logic [1:0] FO_SET = 2'h1;
  localparam logic [1:0] FO_CLR = 2'h2;
  localparam int FLAG_OFFLINE = 0;
  localparam int FLAG_INT = 15;
  localparam int PBUF_BYTES = 8;
  localparam logic [3:0] PBUF_REFILL = 4'h6;
  localparam logic [23:0] PROC_STEP = 24'h000002;
  localparam logic [23:0] RST_WORD = 24'h000000;
  localparam logic [15:0] RST_FLAGS = 16'h0000;
endpackage

// file: hw/scratch_if.sv
// Port bundle between the datapath and its scratch memory.
`timescale 1ns/1ns
`default_nettype none
interface scratch_if #(parameter int AW = 4, parameter int DW = 24);
  logic [AW-1:0] addr;
  logic we;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;
  modport ctrl (output addr, output we, output wdata, input rdata);
  modport mem (input addr, input we, input wdata, output rdata);
endinterface
`default_nettype wire

// file: hw/scratch_mem.sv
// Single-port scratch memory with registered read data.
`timescale 1ns/1ns
`default_nettype none
module scratch_mem #(
  parameter int AW = 4,
  parameter int DW = 24
) (
  input wire logic core_clk, // step clock
  input wire logic srst, // synchronous reset
  scratch_if.mem port // address, strobe and data
);
  logic [DW-1:0] mem [2**AW];

  // One port only: a write cycle leaves the read register untouched.
  always_ff @(posedge core_clk) begin
    if (port.we) begin
      mem[port.addr] <= port.wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      port.rdata <= '0;
    end else if (!port.we) begin
      port.rdata <= mem[port.addr];
    end
  end

  property p_scratch_port;
    @(posedge core_clk) disable iff (srst)
    port.we |=> port.rdata == $past(port.rdata);
  endproperty
  a_scratch_port: assert property (p_scratch_port) else $error("scratch read during write");
endmodule
`default_nettype wire

// file: hw/microcoded_datapath_buses.sv
// Datapath of a microprogrammed 24-bit engine with its backplane requester.
`timescale 1ns/1ns
`default_nettype none
module microcoded_datapath_buses #(
  parameter logic [5:0] OWN_ID = 6'h01, // backplane channel; arbitrary value
  parameter int DBUF_DEPTH = 2
) (
  input wire logic core_clk, // step clock
  input wire logic srst, // synchronous reset
  input wire logic [95:0] uinst, // current microword
  input wire logic step_valid, // microword present
  output logic step_done, // step commits this edge
  output logic stall, // step held this edge
  output logic [7:0] proc_byte, // head procedure byte for the op register
  output logic [15:0] flags, // firmware flags
  output logic offline, // off-line indication
  output logic [5:0] int_source, // requester of last interrupt
  output logic [23:0] z_bus, // result bus
  input wire logic bp_pri_in, // higher-priority element requesting
  output logic bp_pri_out, // priority chain onward
  output logic bp_req_valid, // request offered
  input wire logic bp_req_ready, // bus taken by this request
  output logic bp_req_write, // 1 write, 0 read
  output logic [23:0] bp_req_addr, // byte address
  output logic [15:0] bp_req_data, // write data
  output logic [5:0] bp_req_tag, // own channel for the response
  input wire logic bp_rsp_valid, // response cycle
  output logic bp_rsp_ready, // response may be taken
  input wire logic [5:0] bp_rsp_tag, // response destination
  input wire logic [15:0] bp_rsp_data, // response data
  input wire logic bp_in_valid, // incoming interrupt transfer
  input wire logic [5:0] bp_in_dest, // its destination channel
  input wire logic [5:0] bp_in_src, // its requester channel
  input wire logic [23:0] bp_in_addr // its address field
);
  localparam int PW = $clog2(DBUF_DEPTH);
  logic [23:0] rf [16];
  logic [23:0] q, hold, addr_a, addr_b, addr_p, capture;
  logic [15:0] out_data;
  logic [7:0] pbuf [dp_pkg::PBUF_BYTES];
  logic [2:0] phead, ptail;
  logic [3:0] pcnt;
  logic [15:0] dbuf [DBUF_DEPTH];
  logic [PW-1:0] drd, dwr;
  logic [PW:0] dcnt;
  logic req_valid, req_write, req_proc, rd_out, rd_proc, discard;
  logic [23:0] req_addr;
  logic [15:0] req_data;
  scratch_if #(.AW(4), .DW(24)) sif ();
  scratch_mem #(.AW(4), .DW(24)) u_scratch (.core_clk(core_clk), .srst(srst), .port(sif.mem));
  // Microword fields, decoded fresh every step.
  wire [3:0] aa = uinst[dp_pkg::F_AA +: 4];
  wire [3:0] ab = uinst[dp_pkg::F_AB +: 4];
  wire [2:0] fn = uinst[dp_pkg::F_FN +: 3];
  wire [1:0] src = uinst[dp_pkg::F_SRC +: 2];
  wire [1:0] dst = uinst[dp_pkg::F_DST +: 2];
  wire [2:0] sh = uinst[dp_pkg::F_SH +: 3];
  wire zsel = uinst[dp_pkg::F_ZS];
  wire [2:0] rot = uinst[dp_pkg::F_ROT +: 3];
  wire [5:0] lanes = uinst[dp_pkg::F_LN +: 6];
  wire [1:0] dsrc = uinst[dp_pkg::F_DS +: 2];
  wire [23:0] lit = uinst[dp_pkg::F_LIT +: 24];
  wire [1:0] sasel = uinst[dp_pkg::F_SA +: 2];
  wire swr = uinst[dp_pkg::F_SW];
  wire [1:0] asel = uinst[dp_pkg::F_AS +: 2];
  wire [2:0] aload = uinst[dp_pkg::F_AL +: 3];
  wire hload = uinst[dp_pkg::F_HL];
  wire oload = uinst[dp_pkg::F_OL];
  wire [1:0] bop = uinst[dp_pkg::F_BO +: 2];
  wire ptake = uinst[dp_pkg::F_PT];
  wire [1:0] fop = uinst[dp_pkg::F_FO +: 2];
  wire [3:0] fidx = uinst[dp_pkg::F_FI +: 4];
  // Stall: memory data not yet back, look-ahead empty, or requester busy.
  wire dbuf_empty = (dcnt == '0);
  wire busy_bus = (bop != 2'h0) && (req_valid || rd_out);
  wire block = (zsel && dbuf_empty) || (ptake && pcnt == 4'h0) || busy_bus;
  assign stall = step_valid && block;
  assign step_done = step_valid && !block;
  wire commit = step_done;
  // Address bus: three local registers and the received-address capture.
  wire [23:0] addr_bus = (asel == 2'h0) ? addr_a :
                         (asel == 2'h1) ? addr_b :
                         (asel == 2'h2) ? addr_p : capture;
  wire [15:0] dbuf_head = dbuf[drd];
  assign proc_byte = pbuf[phead];
  // Operand bus: secondary word, then per-lane choice.
  wire [23:0] sec = (dsrc == 2'h0) ? sif.rdata :
                    (dsrc == 2'h1) ? addr_bus :
                    (dsrc == 2'h2) ? {16'h0000, proc_byte} : q;
  wire [23:0] rot_out, d_bus;
  for (genvar g = 0; g < 3; g++) begin : g_lane
    wire [1:0] m = lanes[2*g +: 2];
    assign d_bus[8*g +: 8] = (m == dp_pkg::LN_LIT) ? lit[8*g +: 8] :
                             (m == dp_pkg::LN_HOLD) ? hold[8*g +: 8] :
                             (m == dp_pkg::LN_ROT) ? rot_out[8*g +: 8] :
                             sec[8*g +: 8];
  end
  // Arithmetic unit: operands from the file, q or the operand bus only.
  wire [23:0] r_op = src[1] ? d_bus : rf[aa];
  wire [23:0] s_op = (src == 2'h0) ? rf[ab] : (src == 2'h2) ? rf[aa] : q;
  wire [23:0] f = (fn == dp_pkg::FN_ADD) ? r_op + s_op :
                  (fn == dp_pkg::FN_SUB) ? r_op - s_op :
                  (fn == dp_pkg::FN_AND) ? (r_op & s_op) :
                  (fn == dp_pkg::FN_OR) ? (r_op | s_op) :
                  (fn == dp_pkg::FN_XOR) ? (r_op ^ s_op) :
                  (fn == dp_pkg::FN_PR) ? r_op :
                  (fn == dp_pkg::FN_PS) ? s_op : ~r_op;
  wire sh48 = (sh == dp_pkg::SH_L48) || (sh == dp_pkg::SH_R48);
  wire [23:0] f_sh = (sh == dp_pkg::SH_L24) ? {f[22:0], 1'b0} :
                     (sh == dp_pkg::SH_R24) ? {1'b0, f[23:1]} :
                     (sh == dp_pkg::SH_L48) ? {f[22:0], q[23]} :
                     (sh == dp_pkg::SH_R48) ? {1'b0, f[23:1]} : f;
  wire [23:0] q_sh = (sh == dp_pkg::SH_L48) ? {q[22:0], 1'b0} : {f[0], q[23:1]};
  // Result bus and rotator.
  assign z_bus = zsel ? {8'h00, dbuf_head} : f;
  wire [2:0] rot_n = (rot > 3'h5) ? 3'h0 : rot;
  wire [47:0] z_dbl = {z_bus, z_bus};
  assign rot_out = z_dbl[(24 - 4 * rot_n) +: 24];
  // Scratch memory port.
  assign sif.addr = (sasel == 2'h0) ? lit[3:0] :
                    (sasel == 2'h1) ? aa :
                    (sasel == 2'h2) ? ab : proc_byte[3:0];
  assign sif.we = commit && swr;
  assign sif.wdata = z_bus;
  always_ff @(posedge core_clk) begin
    if (commit && dst != 2'h0 && dst != 2'h2) begin
      rf[ab] <= f_sh;
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      q <= dp_pkg::RST_WORD;
      hold <= dp_pkg::RST_WORD;
      out_data <= dp_pkg::RST_WORD[15:0];
    end else if (commit) begin
      if (dst == 2'h2 || (dst == 2'h3 && !sh48)) q <= f;
      else if (dst == 2'h3) q <= q_sh;
      if (hload) hold <= rot_out;
      if (oload) out_data <= d_bus[15:0];
    end
  end
  // Address registers load from the result bus; the procedure one also advances on fetch.
  // A reload holds off the prefetch for that edge, so no fetch of the old address slips out.
  wire flush = commit && aload[2];
  wire fetch_go = !req_valid && !rd_out && pcnt <= dp_pkg::PBUF_REFILL &&
                  !(commit && bop != 2'h0) && !flush;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      addr_a <= dp_pkg::RST_WORD;
      addr_b <= dp_pkg::RST_WORD;
      addr_p <= dp_pkg::RST_WORD;
    end else begin
      if (commit && aload[0]) addr_a <= z_bus;
      if (commit && aload[1]) addr_b <= z_bus;
      if (flush) addr_p <= z_bus;
      else if (fetch_go) addr_p <= addr_p + dp_pkg::PROC_STEP;
    end
  end
  // Requester: one request slot and at most one read outstanding.
  wire accept = req_valid && bp_req_ready && !bp_pri_in;
  wire rsp_hit = bp_rsp_valid && bp_rsp_ready && bp_rsp_tag == OWN_ID;
  wire proc_rsp = rsp_hit && rd_proc;
  assign bp_req_valid = req_valid && !bp_pri_in;
  assign bp_pri_out = bp_pri_in || req_valid;
  assign bp_req_write = req_write;
  assign bp_req_addr = req_addr;
  assign bp_req_data = req_data;
  assign bp_req_tag = OWN_ID;
  assign bp_rsp_ready = rd_out && (rd_proc || dcnt != DBUF_DEPTH[PW:0]);
  always_ff @(posedge core_clk) begin
    if (srst) begin
      req_valid <= 1'b0;
      req_write <= 1'b0;
      req_proc <= 1'b0;
      req_addr <= dp_pkg::RST_WORD;
      req_data <= dp_pkg::RST_WORD[15:0];
      rd_out <= 1'b0;
      rd_proc <= 1'b0;
    end else begin
      if (commit && bop != 2'h0) begin
        req_valid <= 1'b1;
        req_write <= (bop == dp_pkg::BO_WRITE);
        req_proc <= 1'b0;
        req_addr <= addr_bus;
        req_data <= out_data;
      end else if (fetch_go) begin
        req_valid <= 1'b1;
        req_write <= 1'b0;
        req_proc <= 1'b1;
        req_addr <= addr_p;
      end else if (accept) begin
        req_valid <= 1'b0;
      end
      if (accept && !req_write) begin
        rd_out <= 1'b1;
        rd_proc <= req_proc;
      end else if (rsp_hit) begin
        rd_out <= 1'b0;
      end
    end
  end
  // Procedure look-ahead; a reload of the procedure address throws away stale bytes.
  wire push2 = proc_rsp && !discard && !flush;
  wire pop = commit && ptake;
  always_ff @(posedge core_clk) begin
    if (srst || flush) begin
      phead <= 3'h0;
      ptail <= 3'h0;
      pcnt <= 4'h0;
    end else begin
      if (push2) begin
        pbuf[ptail] <= bp_rsp_data[15:8];
        pbuf[ptail + 3'h1] <= bp_rsp_data[7:0];
        ptail <= ptail + 3'h2;
      end
      if (pop) phead <= phead + 3'h1;
      pcnt <= pcnt + (push2 ? 4'h2 : 4'h0) - (pop ? 4'h1 : 4'h0);
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      discard <= 1'b0;
    end else if (flush && ((rd_out && rd_proc && !proc_rsp) || (req_valid && req_proc))) begin
      discard <= 1'b1;
    end else if (proc_rsp) begin
      discard <= 1'b0;
    end
  end
  // Two-word read data buffer; it back-pressures the response through bp_rsp_ready.
  wire dpush = rsp_hit && !rd_proc;
  wire dpop = commit && zsel;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      drd <= '0;
      dwr <= '0;
      dcnt <= '0;
    end else begin
      if (dpush) begin
        dbuf[dwr] <= bp_rsp_data;
        dwr <= dwr + 1'b1;
      end
      if (dpop) drd <= drd + 1'b1;
      dcnt <= dcnt + {{PW{1'b0}}, dpush} - {{PW{1'b0}}, dpop};
    end
  end
  // Flags and interrupt capture; a hardware set wins over a firmware clear.
  wire in_hit = bp_in_valid && bp_in_dest == OWN_ID;
  always_ff @(posedge core_clk) begin
    if (srst) begin
      flags <= dp_pkg::RST_FLAGS;
      capture <= dp_pkg::RST_WORD;
      int_source <= 6'h00;
    end else begin
      if (commit && fop == dp_pkg::FO_SET) flags[fidx] <= 1'b1;
      else if (commit && fop == dp_pkg::FO_CLR) flags[fidx] <= 1'b0;
      if (in_hit) begin
        flags[dp_pkg::FLAG_INT] <= 1'b1;
        capture <= bp_in_addr;
        int_source <= bp_in_src;
      end
    end
  end
  assign offline = flags[dp_pkg::FLAG_OFFLINE];
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // Right rotation by six minus n nibbles, built from shifts so it does not share the slice above.
  wire [23:0] rot_right = (z_bus >> (4 * (6 - rot_n))) | (z_bus << (24 - 4 * (6 - rot_n)));
  sequence s_read_taken; accept && !req_write; endsequence
  sequence s_write_taken; accept && req_write; endsequence
  property p_rot_equiv;
    rot_n != 3'h0 |-> rot_out == rot_right;
  endproperty
  a_rot_equiv: assert property (p_rot_equiv) else $error("rotation mismatch");
  property p_proc_stall;
    step_valid && ptake && pcnt == 4'h0 |-> stall && !step_done;
  endproperty
  a_proc_stall: assert property (p_proc_stall) else $error("empty look-ahead not stalled");
  property p_zmem_stall;
    step_valid && zsel && dbuf_empty |-> stall;
  endproperty
  a_zmem_stall: assert property (p_zmem_stall) else $error("empty data buffer used");
  property p_read_two;
    s_read_taken |=> rd_out && !req_valid;
  endproperty
  a_read_two: assert property (p_read_two) else $error("read not held for response");
  property p_write_one;
    s_write_taken |=> !rd_out && !req_valid;
  endproperty
  a_write_one: assert property (p_write_one) else $error("write not done in one cycle");
  property p_pri;
    req_valid |-> bp_pri_out && (bp_req_valid == !bp_pri_in);
  endproperty
  a_pri: assert property (p_pri) else $error("priority chain broken");
  property p_int_capture;
    in_hit |=> capture == $past(bp_in_addr) && flags[dp_pkg::FLAG_INT];
  endproperty
  a_int_capture: assert property (p_int_capture) else $error("interrupt not captured");
  property p_hold;
    commit && hload |=> hold == $past(rot_out);
  endproperty
  a_hold: assert property (p_hold) else $error("hold register not loaded");
  property p_flag_set;
    commit && fop == dp_pkg::FO_SET |=> flags[$past(fidx)];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("flag not set");
  property p_addr_load;
    commit && aload[0] |=> addr_a == $past(z_bus);
  endproperty
  a_addr_load: assert property (p_addr_load) else $error("address register not loaded");
  property p_no_commit;
    !commit |=> hold == $past(hold) && addr_a == $past(addr_a);
  endproperty
  a_no_commit: assert property (p_no_commit) else $error("load without step");
endmodule
`default_nettype wire

// file: sim/bp_partner.sv
// Behavioural backplane element that answers reads after a delay and logs writes.
`timescale 1ns/1ns
`default_nettype none
module bp_partner (
  input wire logic core_clk, // step clock
  input wire logic srst, // synchronous reset
  input wire logic [3:0] delay, // read answer delay
  input wire logic bp_req_valid, // request offered
  output logic bp_req_ready, // request taken
  input wire logic bp_req_write, // 1 write
  input wire logic [23:0] bp_req_addr, // address
  input wire logic [15:0] bp_req_data, // write data
  input wire logic [5:0] bp_req_tag, // requester channel
  output logic bp_rsp_valid, // response cycle
  input wire logic bp_rsp_ready, // response taken
  output logic [5:0] bp_rsp_tag, // destination
  output logic [15:0] bp_rsp_data, // read data
  output var int wr_count, // writes seen
  output logic [23:0] wr_addr, // last write address
  output logic [15:0] wr_data // last write data
);
  logic busy;
  logic [3:0] cnt;
  logic [23:0] rd_addr;
  // Only one read is served at a time, as the requester allows no more.
  assign bp_req_ready = !busy;
  always @(posedge core_clk) begin
    if (srst) begin
      busy <= 1'b0;
      bp_rsp_valid <= 1'b0;
      bp_rsp_tag <= 6'h3f;
      bp_rsp_data <= 16'hffff;
      wr_count <= 0;
    end else begin
      if (bp_req_valid && !busy) begin
        if (bp_req_write) begin
          wr_count <= wr_count + 1;
          wr_addr <= bp_req_addr;
          wr_data <= bp_req_data;
        end else begin
          busy <= 1'b1;
          cnt <= delay;
          rd_addr <= bp_req_addr;
          bp_rsp_tag <= bp_req_tag;
        end
      end
      if (busy && !bp_rsp_valid) begin
        if (cnt == 4'h0) begin
          bp_rsp_valid <= 1'b1;
          bp_rsp_data <= {rd_addr[7:0], rd_addr[15:8]} ^ 16'h5a3c;
        end else begin
          cnt <= cnt - 4'h1;
        end
      end
      if (bp_rsp_valid && bp_rsp_ready) begin
        // Released lines show the inverse so stale data cannot pass as fresh.
        bp_rsp_valid <= 1'b0;
        busy <= 1'b0;
        bp_rsp_data <= ~bp_rsp_data;
        bp_rsp_tag <= ~bp_rsp_tag;
      end
    end
  end
endmodule
`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench for the microcoded datapath and its backplane requester.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [95:0] uinst = '0;
  logic step_valid = 1'b0;
  logic step_done, stall, bp_pri_out, bp_req_valid, bp_req_ready, bp_req_write;
  logic bp_rsp_valid, bp_rsp_ready, offline;
  logic [7:0] proc_byte;
  logic [15:0] flags, bp_req_data, bp_rsp_data, wr_data;
  logic [5:0] int_source, bp_req_tag, bp_rsp_tag;
  logic [23:0] z_bus, bp_req_addr, wr_addr;
  logic bp_pri_in = 1'b0;
  logic bp_in_valid = 1'b0;
  logic [5:0] bp_in_dest = 6'h00;
  logic [5:0] bp_in_src = 6'h00;
  logic [23:0] bp_in_addr = 24'h000000;
  logic [3:0] delay = 4'h3;
  logic [23:0] zc, last_out;
  logic [7:0] pc;
  int wr_count, err_total = 0, n_checks = 0, cyc = 0;
  initial forever #2 core_clk = ~core_clk;
  microcoded_datapath_buses #(.OWN_ID(6'h01)) DUT (.core_clk(core_clk), .srst(srst),
    .uinst(uinst), .step_valid(step_valid), .step_done(step_done), .stall(stall),
    .proc_byte(proc_byte), .flags(flags), .offline(offline), .int_source(int_source),
    .z_bus(z_bus), .bp_pri_in(bp_pri_in), .bp_pri_out(bp_pri_out),
    .bp_req_valid(bp_req_valid), .bp_req_ready(bp_req_ready), .bp_req_write(bp_req_write),
    .bp_req_addr(bp_req_addr), .bp_req_data(bp_req_data), .bp_req_tag(bp_req_tag),
    .bp_rsp_valid(bp_rsp_valid), .bp_rsp_ready(bp_rsp_ready), .bp_rsp_tag(bp_rsp_tag),
    .bp_rsp_data(bp_rsp_data), .bp_in_valid(bp_in_valid), .bp_in_dest(bp_in_dest),
    .bp_in_src(bp_in_src), .bp_in_addr(bp_in_addr));
  bp_partner partner (.core_clk(core_clk), .srst(srst), .delay(delay),
    .bp_req_valid(bp_req_valid), .bp_req_ready(bp_req_ready), .bp_req_write(bp_req_write),
    .bp_req_addr(bp_req_addr), .bp_req_data(bp_req_data), .bp_req_tag(bp_req_tag),
    .bp_rsp_valid(bp_rsp_valid), .bp_rsp_ready(bp_rsp_ready), .bp_rsp_tag(bp_rsp_tag),
    .bp_rsp_data(bp_rsp_data), .wr_count(wr_count), .wr_addr(wr_addr), .wr_data(wr_data));
  function automatic logic [95:0] fld(input int pos, input logic [23:0] v);
    return {72'h0, v} << pos;
  endfunction
  function automatic logic [15:0] mem_word(input logic [23:0] a);
    return {a[7:0], a[15:8]} ^ 16'h5a3c;
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Holds the microword until the step commits; z and the head byte are taken before it.
  task automatic step(input logic [95:0] u);
    int k;
    k = 0;
    @(negedge core_clk);
    uinst = u;
    step_valid = 1'b1;
    #1;
    while (step_done !== 1'b1 && k < 300) begin
      @(negedge core_clk);
      #1;
      k++;
    end
    check("step_done", 24'h1, 24'(step_done));
    zc = z_bus;
    pc = proc_byte;
    @(posedge core_clk);
    @(negedge core_clk);
    step_valid = 1'b0;
  endtask
  task automatic write_chk(input logic [1:0] as, input logic [23:0] ea, input logic [15:0] ed,
                           input bit pri);
    int n, k;
    n = wr_count;
    k = 0;
    step(fld(dp_pkg::F_BO, 24'(dp_pkg::BO_WRITE)) | fld(dp_pkg::F_AS, 24'(as)));
    if (pri) begin
      bp_pri_in = 1'b1;
      repeat (3) begin
        #1;
        check("req_valid_blocked", 24'h0, 24'(bp_req_valid));
        check("pri_out", 24'h1, 24'(bp_pri_out));
        @(negedge core_clk);
      end
      bp_pri_in = 1'b0;
    end
    while (wr_count == n && k < 300) begin
      @(negedge core_clk);
      k++;
    end
    check("write_count", 24'(n + 1), 24'(wr_count));
    check("write_addr", ea, wr_addr);
    check("write_data", 24'(ed), 24'(wr_data));
  endtask
  task automatic t_proc();
    logic [15:0] w;
    @(negedge core_clk);
    uinst = fld(dp_pkg::F_PT, 24'h1);
    step_valid = 1'b1;
    #1;
    check("stall_empty", 24'h1, 24'(stall));
    for (int k = 0; k < 12; k++) begin
      w = mem_word(24'(2 * (k / 2)));
      step(fld(dp_pkg::F_PT, 24'h1));
      check("proc_byte", 24'((k % 2 == 0) ? w[15:8] : w[7:0]), 24'(pc));
    end
    $display("test proc done");
  endtask
  task automatic t_rot();
    logic [23:0] x;
    logic [47:0] t;
    logic [1:0] l0;
    x = {8'h00, mem_word(24'h0)};
    delay = 4'h0;
    for (int r = 0; r < 6; r++) begin
      t = {x, x} >> (4 * ((6 - r) % 6));
      l0 = (r % 2 == 1) ? dp_pkg::LN_LIT : dp_pkg::LN_HOLD;
      step(fld(dp_pkg::F_BO, 24'(dp_pkg::BO_READ)));
      step(fld(dp_pkg::F_ZS, 24'h1) | fld(dp_pkg::F_HL, 24'h1) | fld(dp_pkg::F_ROT, 24'(r)));
      check("z_read", x, zc);
      step(fld(dp_pkg::F_OL, 24'h1) | fld(dp_pkg::F_LIT, 24'h0000c7) |
           fld(dp_pkg::F_LN, {18'h0, dp_pkg::LN_HOLD, dp_pkg::LN_HOLD, l0}));
      last_out = {8'h00, t[15:8], (r % 2 == 1) ? 8'hc7 : t[7:0]};
      write_chk(2'h0, 24'h0, last_out[15:0], r == 0);
    end
    $display("test rot done");
  endtask
  task automatic t_fill();
    logic [23:0] a;
    int k;
    a = {8'h00, mem_word(24'h0)};
    k = 0;
    step(fld(dp_pkg::F_BO, 24'(dp_pkg::BO_READ)));
    step(fld(dp_pkg::F_ZS, 24'h1) | fld(dp_pkg::F_AL, 24'h1));
    step(fld(dp_pkg::F_BO, 24'(dp_pkg::BO_READ)));
    step(fld(dp_pkg::F_BO, 24'(dp_pkg::BO_READ)) | fld(dp_pkg::F_AS, 24'h1));
    step(fld(dp_pkg::F_BO, 24'(dp_pkg::BO_READ)));
    while (bp_rsp_valid !== 1'b1 && k < 50) begin
      @(negedge core_clk);
      k++;
    end
    check("rsp_pending", 24'h1, 24'(bp_rsp_valid));
    repeat (4) begin
      check("rsp_ready_full", 24'h0, 24'(bp_rsp_ready));
      @(negedge core_clk);
    end
    step(fld(dp_pkg::F_ZS, 24'h1));
    check("drain0", {8'h00, mem_word(a)}, zc);
    step(fld(dp_pkg::F_ZS, 24'h1));
    check("drain1", {8'h00, mem_word(24'h0)}, zc);
    step(fld(dp_pkg::F_ZS, 24'h1));
    check("drain2", {8'h00, mem_word(a)}, zc);
    $display("test fill done");
  endtask
  task automatic t_flags();
    logic [15:0] e;
    e = 16'h0000;
    for (int i = 0; i < 16; i++) begin
      step(fld(dp_pkg::F_FO, 24'(dp_pkg::FO_SET)) | fld(dp_pkg::F_FI, 24'(i)));
      e[i] = 1'b1;
      check("flags_set", 24'(e), 24'(flags));
    end
    check("offline", 24'h1, 24'(offline));
    for (int i = 0; i < 16; i++) begin
      step(fld(dp_pkg::F_FO, 24'(dp_pkg::FO_CLR)) | fld(dp_pkg::F_FI, 24'(i)));
    end
    check("flags_clr", 24'h0, 24'(flags));
    $display("test flags done");
  endtask
  task automatic send_int(input logic [5:0] d, input logic [5:0] s);
    @(negedge core_clk);
    bp_in_valid = 1'b1;
    bp_in_dest = d;
    bp_in_src = s;
    bp_in_addr = 24'h3c0f12;
    @(negedge core_clk);
    bp_in_valid = 1'b0;
    @(negedge core_clk);
  endtask
  task automatic t_int();
    send_int(6'h02, 6'h15);
    check("int_other", 24'h0, 24'(flags[15]));
    send_int(6'h01, 6'h2a);
    check("int_flag", 24'h1, 24'(flags[15]));
    check("int_source", 24'h00002a, 24'(int_source));
    write_chk(2'h3, 24'h3c0f12, last_out[15:0], 1'b0);
    $display("test int done");
  endtask
  // Result bus word goes into scratch word 5, comes back through the operand bus to the bus.
  task automatic t_scratch();
    logic [23:0] v;
    v = {8'h00, mem_word({8'h00, mem_word(24'h0)})};
    step(fld(dp_pkg::F_BO, 24'(dp_pkg::BO_READ)));
    step(fld(dp_pkg::F_ZS, 24'h1) | fld(dp_pkg::F_SW, 24'h1) |
         fld(dp_pkg::F_LIT, 24'h000005));
    check("z_scratch", v, zc);
    step(fld(dp_pkg::F_LIT, 24'h00000a));
    step(fld(dp_pkg::F_LIT, 24'h000005));
    step(fld(dp_pkg::F_OL, 24'h1) | fld(dp_pkg::F_LIT, 24'h000005) |
         fld(dp_pkg::F_LN, 24'h00003f));
    write_chk(2'h0, {8'h00, mem_word(24'h0)}, v[15:0], 1'b0);
    $display("test scratch done");
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_total++;
      $display("timeout reached");
      stop_test();
    end
  end
  initial begin
    repeat (6) @(posedge core_clk);
    @(negedge core_clk);
    srst = 1'b0;
    t_proc();
    t_rot();
    t_fill();
    t_flags();
    t_int();
    t_scratch();
    stop_test();
  end
endmodule
`default_nettype wire
